// ---- hdl/asc_host.sv ----
// host controller driving a 256K x 16 async sram with byte lanes
// assumes a 10 MHz clock; one access at a time from the user port
`timescale 1ns/1ns
`include "asc_defines.svh"
// Function
// - write happens only while select, a lane and write enable overlap
// - write begins with all three valid, ends when any releases
// - data setup and hold measured from the write-ending edge
// - write data valid 9 ns before write end, hold 0 ns
// - write data stays stable at least 0 ns after write end
// - address valid at least 12 ns before write end
// - address unchanged at least 0 ns after write end
// - lane selects low at least 12 ns before write end
// - write enable pulse at least 17 ns when output enable low
// - cycle with outputs on is release delay plus data setup
// - address valid no later than chip select falling
module asc_host
    import asc_pkg::*;
(
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst,
    input  wire logic                   i_ce,
    input  wire logic                   i_req_valid,
    input  wire logic                   i_req_write,
    input  wire logic [`ASC_ADDR_W-1:0] i_req_addr,
    input  wire logic [`ASC_DATA_W-1:0] i_req_wdata,
    input  wire logic [1:0]             i_req_lanes,
    output logic                        o_req_ready,
    output logic                        o_rsp_valid,
    output logic [`ASC_DATA_W-1:0]      o_rsp_rdata,
    output logic [`ASC_ADDR_W-1:0]      o_sram_addr,
    output logic                        o_chip_select_n,
    output logic                        o_write_enable_n,
    output logic                        o_output_enable_n,
    output logic                        o_low_lane_select_n,
    output logic                        o_high_lane_select_n,
    input  wire logic [`ASC_DATA_W-1:0] i_sram_dq,
    output logic [`ASC_DATA_W-1:0]      o_sram_dq,
    output logic                        o_sram_dq_oe_n
);
    localparam logic [3:0] WR_CYC  = 4'(`ASC_WR_PULSE_CYC);
    localparam logic [3:0] RD_CYC  = 4'(`ASC_RD_WAIT_CYC + 2);
    localparam logic [3:0] GAP_CYC = 4'(`ASC_CYCLE_CYC);

    asc_state_t                 state_r;
    asc_state_t                 state_nxt;
    logic [3:0]                 cnt_r;
    logic                       is_write_r;
    logic [1:0]                 lanes_r;
    logic [`ASC_DATA_W-1:0]     dq_sync;
    logic [1:0]                 lanes_sel;
    logic                       take;
    logic                       rd_done;

    // lane mask to active-low select pair
    function automatic logic [1:0] lane_sel_n(input logic [1:0] lanes);
        lane_sel_n = ~lanes;
    endfunction

    // pins are driven active in the write pulse and read states, not in the gap
    function automatic logic access_on(input asc_state_t st);
        access_on = (st == ASC_WPUL) || (st == ASC_RSET) || (st == ASC_RWAIT);
    endfunction

    // read data passes two flops since the pins are asynchronous
    asc_sync2 #(.W(`ASC_DATA_W)) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_d       (i_sram_dq),
        .o_q       (dq_sync)
    );

    assign o_req_ready = (state_r == ASC_IDLE) && (i_req_lanes != 2'h0);
    assign take        = i_req_valid && o_req_ready;
    assign rd_done     = (state_r == ASC_RWAIT) && (cnt_r == 4'h0) && !is_write_r;

    // lanes come from the request on the accept edge and from the latch after it;
    // the latch alone would select the previous access's lanes for one cycle
    assign lanes_sel = (state_r == ASC_IDLE) ? i_req_lanes : lanes_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ASC_IDLE: begin
                if (i_req_valid && o_req_ready) begin
                    state_nxt = i_req_write ? ASC_WPUL : ASC_RSET;
                end
            end
            ASC_RSET:  state_nxt = ASC_RWAIT;
            ASC_RWAIT: if (cnt_r == 4'h0) state_nxt = ASC_GAP;
            ASC_WPUL:  if (cnt_r == 4'h0) state_nxt = ASC_GAP;
            ASC_GAP:   if (cnt_r == 4'h0) state_nxt = ASC_IDLE;
            default:   state_nxt = ASC_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_r <= ASC_IDLE;
        end else if (i_ce) begin
            state_r <= state_nxt;
        end
    end

    // counter: one write pulse of whole 100 ns cycles covers 12/17 ns
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt_r <= 4'h0;
        end else if (i_ce) begin
            if (state_r == ASC_IDLE && state_nxt == ASC_WPUL) begin
                cnt_r <= WR_CYC - 4'h1;
            end else if (state_r == ASC_RSET) begin
                cnt_r <= RD_CYC - 4'h1;
            end else if (state_r != ASC_GAP && state_nxt == ASC_GAP) begin
                cnt_r <= GAP_CYC - 4'h1;
            end else if (cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end

    // address and write data latched at accept and held through the gap
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_sram_addr <= '0;
            o_sram_dq   <= '0;
        end else if (i_ce && take) begin
            o_sram_addr <= i_req_addr;
            o_sram_dq   <= i_req_wdata;
        end
    end

    // request kind and lane mask kept for the rest of the access
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            lanes_r    <= 2'h0;
            is_write_r <= 1'b0;
        end else if (i_ce && take) begin
            lanes_r    <= i_req_lanes;
            is_write_r <= i_req_write;
        end
    end

    // the write ends by write enable, chip select and lanes rising at one edge
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_chip_select_n  <= 1'b1;
            o_write_enable_n <= 1'b1;
        end else if (i_ce) begin
            o_chip_select_n  <= ~access_on(state_nxt);
            o_write_enable_n <= ~(state_nxt == ASC_WPUL);
        end
    end

    // output enable stays high through writes, so no stale read data meets them;
    // only reads open the device buffers
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_output_enable_n <= 1'b1;
        end else if (i_ce) begin
            o_output_enable_n <= ~(state_nxt == ASC_RSET || state_nxt == ASC_RWAIT);
        end
    end

    // lane selects stand for the whole pulse, leading the write end by a cycle
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_high_lane_select_n <= 1'b1;
            o_low_lane_select_n  <= 1'b1;
        end else if (i_ce) begin
            if (access_on(state_nxt)) begin
                {o_high_lane_select_n, o_low_lane_select_n} <= lane_sel_n(lanes_sel);
            end else begin
                o_high_lane_select_n <= 1'b1;
                o_low_lane_select_n  <= 1'b1;
            end
        end
    end

    // data stays driven one cycle past write enable rising for the hold
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_sram_dq_oe_n <= 1'b1;
        end else if (i_ce) begin
            o_sram_dq_oe_n <= !(state_nxt == ASC_WPUL || state_r == ASC_WPUL);
        end
    end

    // one-cycle answer strobe as the read wait runs out
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rsp_valid <= 1'b0;
        end else if (i_ce) begin
            o_rsp_valid <= rd_done;
        end
    end

    // read capture after synchroniser latency; unselected lanes read zero
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rsp_rdata <= '0;
        end else if (i_ce && rd_done) begin
            o_rsp_rdata <= dq_sync & {{8{lanes_r[1]}}, {8{lanes_r[0]}}};
        end
    end
endmodule

// ---- hdl/asc_defines.svh ----
// timing counts and field widths for the async sram host controller
// assumes a 10 MHz reference clock (100 ns period)
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH
`define ASC_CLK_PERIOD_NS            100
`define ASC_ADDR_W                   18
`define ASC_DATA_W                   16
// times in ns as printed
`define ASC_READ_CYCLE_MIN_NS        20
`define ASC_ADDRESS_TO_DATA_DELAY_NS 20
`define ASC_WRITE_CYCLE_MIN_NS       20
`define ASC_WRITE_PULSE_MIN_NS       12
`define ASC_WRITE_PULSE_OE_NS        17
`define ASC_WRITE_DATA_SETUP_NS      9
`define ASC_ADDR_SETUP_END_NS        12
// least times round up, never below one cycle
`define ASC_CEIL_CYC(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_MAX1(x) (((x) < 1) ? 1 : (x))
`define ASC_WR_PULSE_CYC `ASC_MAX1(`ASC_CEIL_CYC(`ASC_WRITE_PULSE_OE_NS))
`define ASC_RD_WAIT_CYC  `ASC_MAX1(`ASC_CEIL_CYC(`ASC_ADDRESS_TO_DATA_DELAY_NS))
`define ASC_CYCLE_CYC    `ASC_MAX1(`ASC_CEIL_CYC(`ASC_READ_CYCLE_MIN_NS))
`endif

// ---- hdl/asc_pkg.sv ----
// types for the async sram host controller
package asc_pkg;
    typedef enum logic [4:0] {
        ASC_IDLE  = 5'h01,
        ASC_RSET  = 5'h02,
        ASC_RWAIT = 5'h04,
        ASC_WPUL  = 5'h08,
        ASC_GAP   = 5'h10
    } asc_state_t;
endpackage

// ---- hdl/asc_sync2.sv ----
// two-flop synchroniser for the sram data pins
// assumes the pins are asynchronous to i_ref_clk
`timescale 1ns/1ns
module asc_sync2 #(
    parameter int W = 16
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            meta_r <= '0;
            o_q    <= '0;
        end else if (i_ce) begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule

// ---- verification/asc_sram_model.sv ----
// behavioural 256K x 16 async sram partner with byte lanes
// assumes the bench resolves the dq wire from both drivers
`timescale 1ns/1ns
module asc_sram_model (
    input  wire logic [17:0] i_addr,
    input  wire logic        i_cs_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_lb_n,
    input  wire logic        i_ub_n,
    input  wire logic [15:0] i_dq,
    output logic      [15:0] o_dq
);
    logic [15:0] mem [0:262143];
    logic [15:0] junk = 16'h5a5a;
    logic        rd;
    // floating lanes show a moving pattern so a stale value never passes
    always #100 junk = ~junk + 16'h3c5b;
    always @* begin
        if (!i_cs_n && !i_we_n && !i_lb_n) mem[i_addr][7:0] = i_dq[7:0];
        if (!i_cs_n && !i_we_n && !i_ub_n) mem[i_addr][15:8] = i_dq[15:8];
    end
    assign rd = !i_cs_n && i_we_n && !i_oe_n;
    assign #8 o_dq[7:0] = (rd && !i_lb_n) ? mem[i_addr][7:0] : junk[7:0];
    assign #8 o_dq[15:8] = (rd && !i_ub_n) ? mem[i_addr][15:8] : junk[15:8];
endmodule

// ---- verification/asc_host_asserts.sv ----
// pin and handshake assertions for the async sram host controller
// bound into asc_host; sees only its ports
`timescale 1ns/1ns
`include "asc_defines.svh"
module asc_host_asserts (
    input wire logic                   i_ref_clk,
    input wire logic                   i_rst,
    input wire logic                   i_ce,
    input wire logic                   i_req_valid,
    input wire logic                   i_req_write,
    input wire logic [`ASC_ADDR_W-1:0] i_req_addr,
    input wire logic [`ASC_DATA_W-1:0] i_req_wdata,
    input wire logic [1:0]             i_req_lanes,
    input wire logic                   o_req_ready,
    input wire logic                   o_rsp_valid,
    input wire logic [`ASC_ADDR_W-1:0] o_sram_addr,
    input wire logic                   o_chip_select_n,
    input wire logic                   o_write_enable_n,
    input wire logic                   o_output_enable_n,
    input wire logic                   o_low_lane_select_n,
    input wire logic                   o_high_lane_select_n,
    input wire logic [`ASC_DATA_W-1:0] o_sram_dq,
    input wire logic                   o_sram_dq_oe_n
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    wire tk = i_ce && i_req_valid && o_req_ready;
    wire [1:0] ln_n = {o_high_lane_select_n, o_low_lane_select_n};
    property p_wr_overlap;
        !o_write_enable_n |-> !o_chip_select_n && o_output_enable_n && ln_n != 2'h3;
    endproperty
    a_wr_overlap: assert property (p_wr_overlap) else $error("stray write");
    property p_wr_go;
        tk && i_req_write |=> !o_write_enable_n && ln_n == ~$past(i_req_lanes)
            && o_sram_addr == $past(i_req_addr) && o_sram_dq == $past(i_req_wdata);
    endproperty
    a_wr_go: assert property (p_wr_go) else $error("bad write launch");
    property p_wr_hold;
        $rose(o_write_enable_n) |-> !o_sram_dq_oe_n && $stable(o_sram_dq) && $stable(o_sram_addr);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write hold broken");
    property p_wr_end;
        $rose(o_write_enable_n) |-> o_chip_select_n && ln_n == 2'h3;
    endproperty
    a_wr_end: assert property (p_wr_end) else $error("write end untidy");
    property p_rd_go;
        tk && !i_req_write |=> !o_chip_select_n && o_write_enable_n && !o_output_enable_n
            && ln_n == ~$past(i_req_lanes) && o_sram_addr == $past(i_req_addr) && o_sram_dq_oe_n;
    endproperty
    a_rd_go: assert property (p_rd_go) else $error("bad read launch");
    property p_rd_rsp;
        tk && !i_req_write |-> ##[3:8] o_rsp_valid;
    endproperty
    a_rd_rsp: assert property (p_rd_rsp) else $error("read response late");
    property p_addr_held;
        !o_chip_select_n ##1 !o_chip_select_n |-> $stable(o_sram_addr);
    endproperty
    a_addr_held: assert property (p_addr_held) else $error("address moved");
    property p_gap;
        $rose(o_chip_select_n) |=> o_chip_select_n;
    endproperty
    a_gap: assert property (p_gap) else $error("no idle gap");
    property p_no_fight;
        !o_sram_dq_oe_n |-> o_output_enable_n;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("bus contention");
    c_write: cover property (tk && i_req_write);
    c_read: cover property (tk && !i_req_write);
    c_refuse: cover property (i_req_valid && !o_req_ready);
endmodule
bind asc_host asc_host_asserts u_chk (.i_ref_clk, .i_rst, .i_ce, .i_req_valid, .i_req_write,
    .i_req_addr, .i_req_wdata, .i_req_lanes, .o_req_ready, .o_rsp_valid, .o_sram_addr,
    .o_chip_select_n, .o_write_enable_n, .o_output_enable_n, .o_low_lane_select_n,
    .o_high_lane_select_n, .o_sram_dq, .o_sram_dq_oe_n);

// ---- verification/testbench.sv ----
// self-checking bench: host controller against the sram model
// assumes 10 MHz clock; reads are scored through an expectation queue
`timescale 1ns/1ns
module testbench;
    logic        clk = 0, i_rst = 1, ce = 1, valid = 0, wr = 0;
    logic        ready, rsp_v, cs_n, we_n, oe_n, lb_n, ub_n, dq_oe_n;
    logic [1:0]  lanes = 2'h1;
    logic [17:0] addr = 0, pin_a;
    logic [15:0] wdata = 0, dq, host_dq, mdl_dq, rdata;
    logic [15:0] ref_mem [0:262143];
    logic [15:0] expq [$];
    int          mismatches = 0, tests_run = 0;
    initial forever #50 clk = ~clk;
    assign dq = !dq_oe_n ? host_dq : mdl_dq;
    asc_host dut (.i_ref_clk(clk), .i_rst(i_rst), .i_ce(ce), .i_req_valid(valid),
        .i_req_write(wr), .i_req_addr(addr), .i_req_wdata(wdata), .i_req_lanes(lanes),
        .o_req_ready(ready), .o_rsp_valid(rsp_v), .o_rsp_rdata(rdata), .o_sram_addr(pin_a),
        .o_chip_select_n(cs_n), .o_write_enable_n(we_n), .o_output_enable_n(oe_n),
        .o_low_lane_select_n(lb_n), .o_high_lane_select_n(ub_n), .i_sram_dq(dq),
        .o_sram_dq(host_dq), .o_sram_dq_oe_n(dq_oe_n));
    asc_sram_model mdl (.i_addr(pin_a), .i_cs_n(cs_n), .i_we_n(we_n), .i_oe_n(oe_n),
        .i_lb_n(lb_n), .i_ub_n(ub_n), .i_dq(dq), .o_dq(mdl_dq));
    task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmp_pins(string nm, logic [5:0] e);
        cmp(nm, {10'h0, e}, {10'h0, cs_n, we_n, oe_n, lb_n, ub_n, dq_oe_n});
    endtask
    // bounded wait until every queued read answer has been scored
    task automatic drain();
        for (int n = 0; expq.size() > 0 && n < 20; n++) @(posedge clk);
        if (expq.size() > 0) begin
            mismatches++;
            end_sim();
        end
    endtask
    // one access; frz cycles of clock-enable low land in the read wait
    task automatic req(logic w, logic [17:0] a, logic [15:0] d, logic [1:0] l, int frz);
        int n;
        n = 0;
        @(posedge clk);
        #1 {wr, addr, wdata, lanes, valid} = {w, a, d, l, 1'b1};
        while (ready !== 1'b1) begin
            @(posedge clk);
            #1 n++;
            if (n > 30) begin
                mismatches++;
                end_sim();
            end
        end
        @(posedge clk);
        #1 valid = 0;
        if (w && l[0]) ref_mem[a][7:0] = d[7:0];
        if (w && l[1]) ref_mem[a][15:8] = d[15:8];
        if (!w) expq.push_back({l[1] ? ref_mem[a][15:8] : 8'h0, l[0] ? ref_mem[a][7:0] : 8'h0});
        if (frz > 0) begin
            @(posedge clk);
            #1 ce = 0;
            repeat (frz) @(posedge clk);
            #1 ce = 1;
        end
    endtask
    always @(posedge clk) begin
        if (rsp_v === 1'b1) cmp("rdata", expq.size() ? expq.pop_front() : 16'hxxxx, rdata);
    end
    initial begin
        logic [17:0] a [3];
        void'($urandom(32'h01ad));
        repeat (16) @(posedge clk);
        #1 i_rst = 0;
        cmp_pins("idle pins", 6'h3f);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            a[i] = 18'($urandom);
            req(1, a[i], 16'hffff ^ 16'(i), 2'h3, 0);
            req(1, a[i], 16'($urandom), 2'(i + 1), 0);
            for (int l = 1; l < 4; l++) req(0, a[i], 0, 2'(l), l - 1);
        end
        drain();
        $display("test lane masks done");
        @(posedge clk);
        #1 {lanes, valid} = 3'b001;
        repeat (4) begin
            @(posedge clk);
            #1 cmp("refused", 16'h1, {14'h0, ready, cs_n});
        end
        valid = 0;
        $display("test refusal done");
        req(1, a[2], 16'h1234, 2'h1, 0);
        i_rst = 1;
        repeat (2) @(posedge clk);
        #1 i_rst = 0;
        cmp_pins("reset pins", 6'h3f);
        req(0, a[2], 0, 2'h3, 0);
        drain();
        $display("test mid-run reset done");
        end_sim();
    end
endmodule
